// file: verilog/asw_ctrl_regs.vh
// Timing constants for the asynchronous static memory controller.
`ifndef ASW_CTRL_REGS_VH
`define ASW_CTRL_REGS_VH

// System clock rate in MHz (20 ns period).
`define ASW_CLK_MHZ 50

// Slowest speed grade minimums in ns, so any grade of part is served.
`define ASW_T_AVEH_NS 20
`define ASW_T_ELEH_NS 15
`define ASW_T_DVEH_NS 10
`define ASW_T_AVAV_NS 25
`define ASW_T_ACC_NS 25

// Least time in ns to whole clock cycles, rounded up, so any nonzero time gives at least one.
`define ASW_NS2CYC(ns) ((((ns) * `ASW_CLK_MHZ) + 999) / 1000)

// Cycle counts derived from the times above.
`define ASW_AVEH_CYC `ASW_NS2CYC(`ASW_T_AVEH_NS)
`define ASW_ELEH_CYC `ASW_NS2CYC(`ASW_T_ELEH_NS)
`define ASW_DVEH_CYC `ASW_NS2CYC(`ASW_T_DVEH_NS)
`define ASW_AVAV_CYC `ASW_NS2CYC(`ASW_T_AVAV_NS)
`define ASW_ACC_CYC `ASW_NS2CYC(`ASW_T_ACC_NS)

// Widths of the memory pins and of the phase timer.
`define ASW_ADDR_W 15
`define ASW_DATA_W 8
`define ASW_TMR_W 4

`endif

// file: verilog/asw_timer.v
// Down counter that times the phases of a memory cycle.
`timescale 1ns/1ps
`default_nettype none
`include "asw_ctrl_regs.vh"

module asw_timer (
    input wire clk,
    input wire srst,
    input wire load,
    input wire [`ASW_TMR_W-1:0] load_val,
    output wire expired
);
    reg [`ASW_TMR_W-1:0] cnt_r;
    reg [`ASW_TMR_W-1:0] cnt_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r != {`ASW_TMR_W{1'b0}}) begin
            cnt_nxt = cnt_r - {{(`ASW_TMR_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            cnt_r <= {`ASW_TMR_W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == {`ASW_TMR_W{1'b0}});
endmodule // asw_timer

`default_nettype wire

// file: verilog/asw_ctrl.v
// Host controller driving an asynchronous static memory over its pins.
`timescale 1ns/1ps
`default_nettype none
`include "asw_ctrl_regs.vh"

// Contract
// - A write happens only while chip select and write strobe overlap low.
// - Address stays valid at least the minimum before chip select rises.
// - Chip select stays low at least the minimum before ending a write.
// - Write data is driven at least the minimum before chip select rises.
// - Successive cycles keep the address valid for the whole cycle time.
// - Write strobe stays high throughout every read cycle.
module asw_ctrl (
    input wire clk,
    input wire srst,
    input wire req,
    input wire req_we,
    input wire [`ASW_ADDR_W-1:0] req_addr,
    input wire [`ASW_DATA_W-1:0] req_wdata,
    output reg ready_r,
    output reg done_r,
    output reg [`ASW_DATA_W-1:0] rdata_r,
    output reg [`ASW_ADDR_W-1:0] mem_addr_r,
    output reg mem_cs_n_r,
    output reg mem_we_n_r,
    output reg mem_oe_n_r,
    output reg [`ASW_DATA_W-1:0] dq_out_r,
    output reg dq_oe_r,
    input wire [`ASW_DATA_W-1:0] dq_in
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_W_SET = 4'h1;
    localparam [3:0] ST_W_PUL = 4'h2;
    localparam [3:0] ST_W_CSH = 4'h3;
    localparam [3:0] ST_W_REL = 4'h4;
    localparam [3:0] ST_GAP = 4'h5;
    localparam [3:0] ST_R_SET = 4'h6;
    localparam [3:0] ST_R_ACC = 4'h7;
    localparam [3:0] ST_R_END = 4'h8;

    // Larger of two cycle counts, used to size the select pulse.
    function integer max_cyc;
        input integer a;
        input integer b;
        begin
            max_cyc = (a > b) ? a : b;
        end
    endfunction

    // The select pulse must satisfy address, select and data minimums at
    // once, since all three are measured to the same rising edge.
    localparam integer PUL_CYC = max_cyc(max_cyc(`ASW_AVEH_CYC,
        `ASW_ELEH_CYC), `ASW_DVEH_CYC);
    // Loads are one less than the cycle count, because a timed state is
    // left in the cycle in which the timer reads zero.
    localparam integer PUL_M1 = PUL_CYC - 1;
    localparam integer GAP_M1 = `ASW_AVAV_CYC - 1;
    localparam integer ACC_M1 = `ASW_ACC_CYC - 1;
    // The timer is four bits wide, so every load must stay below sixteen.
    localparam [`ASW_TMR_W-1:0] PUL_LOAD = PUL_M1[`ASW_TMR_W-1:0];
    localparam [`ASW_TMR_W-1:0] GAP_LOAD = GAP_M1[`ASW_TMR_W-1:0];
    localparam [`ASW_TMR_W-1:0] ACC_LOAD = ACC_M1[`ASW_TMR_W-1:0];

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg tmr_load;
    reg [`ASW_TMR_W-1:0] tmr_val;
    wire tmr_expired;
    wire take_req;
    wire rd_capture;
    wire [3:0] pins_nxt;

    // Pin levels for a state: {cs_n, we_n, oe_n, dq_oe}.
    function [3:0] pin_levels;
        input [3:0] st;
        begin
            case (st)
                ST_W_SET: pin_levels = 4'b1011;
                ST_W_PUL: pin_levels = 4'b0011;
                ST_W_CSH: pin_levels = 4'b1011;
                ST_W_REL: pin_levels = 4'b1111;
                ST_R_SET: pin_levels = 4'b1110;
                ST_R_ACC: pin_levels = 4'b0100;
                default: pin_levels = 4'b1110;
            endcase
        end
    endfunction

    // Pins are decoded from the next state so that each registered pin
    // changes on the same edge as the state, with no cycle of lag.
    assign pins_nxt = pin_levels(state_nxt);
    assign take_req = (state_r == ST_IDLE) && req;
    // Read data is taken in the last access cycle, while select and output
    // enable are still low and the memory is still driving the lines.
    assign rd_capture = (state_r == ST_R_ACC) && tmr_expired;

    // One timer serves pulse, gap and access; those phases never overlap.
    asw_timer u_timer (
        .clk(clk),
        .srst(srst),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    // Writes are select-timed: the strobe brackets select by a cycle on each
    // side, so the memory never turns its data pins on during a write.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (req) begin
                    state_nxt = req_we ? ST_W_SET : ST_R_SET;
                end
            end
            ST_W_SET: state_nxt = ST_W_PUL;
            ST_W_PUL: begin
                if (tmr_expired) begin
                    state_nxt = ST_W_CSH;
                end
            end
            ST_W_CSH: state_nxt = ST_W_REL;
            ST_W_REL: state_nxt = ST_GAP;
            ST_GAP: begin
                if (tmr_expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_R_SET: state_nxt = ST_R_ACC;
            ST_R_ACC: begin
                if (tmr_expired) begin
                    state_nxt = ST_R_END;
                end
            end
            ST_R_END: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // The timer is loaded only on entry to a timed state.
    always @* begin
        tmr_load = 1'b0;
        tmr_val = {`ASW_TMR_W{1'b0}};
        if (state_nxt != state_r) begin
            case (state_nxt)
                ST_W_PUL: begin
                    tmr_load = 1'b1;
                    tmr_val = PUL_LOAD;
                end
                ST_GAP: begin
                    tmr_load = 1'b1;
                    tmr_val = GAP_LOAD;
                end
                ST_R_ACC: begin
                    tmr_load = 1'b1;
                    tmr_val = ACC_LOAD;
                end
                default: begin
                    tmr_load = 1'b0;
                    tmr_val = {`ASW_TMR_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The address only moves when a new request is taken in idle, so it
    // stays put from before select falls until the cycle time has run.
    // Data is loaded for reads as well; that is harmless, since the data
    // lines are driven only inside a write.
    always @(posedge clk) begin
        if (srst) begin
            mem_addr_r <= {`ASW_ADDR_W{1'b0}};
            dq_out_r <= {`ASW_DATA_W{1'b0}};
        end else if (take_req) begin
            mem_addr_r <= req_addr;
            dq_out_r <= req_wdata;
        end
    end

    // Ready rises with done, so a request may follow back to back in the
    // done cycle; after a write the cycle-time gap has already run by then.
    always @(posedge clk) begin
        if (srst) begin
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= {`ASW_DATA_W{1'b0}};
        end else begin
            ready_r <= (state_nxt == ST_IDLE);
            done_r <= (state_nxt == ST_IDLE) && (state_r != ST_IDLE);
            if (rd_capture) begin
                rdata_r <= dq_in;
            end
        end
    end

    // Reset drops every strobe and releases the data lines, so a reset in
    // mid-write cannot leave the memory selected.
    always @(posedge clk) begin
        if (srst) begin
            mem_cs_n_r <= 1'b1;
            mem_we_n_r <= 1'b1;
            mem_oe_n_r <= 1'b1;
            dq_oe_r <= 1'b0;
        end else begin
            mem_cs_n_r <= pins_nxt[3];
            mem_we_n_r <= pins_nxt[2];
            mem_oe_n_r <= pins_nxt[1];
            dq_oe_r <= pins_nxt[0];
        end
    end
endmodule // asw_ctrl

`default_nettype wire

// file: verif/asw_ctrl_monitor.sv
// Pin-order checker for the static memory controller.
`timescale 1ns/1ps
`default_nettype none
`include "asw_ctrl_regs.vh"
module asw_ctrl_monitor (
    input wire clk,
    input wire srst,
    input wire req,
    input wire req_we,
    input wire ready_r,
    input wire done_r,
    input wire [`ASW_ADDR_W-1:0] mem_addr_r,
    input wire mem_cs_n_r,
    input wire mem_we_n_r,
    input wire mem_oe_n_r,
    input wire dq_oe_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_done_latency: assert property (
        ready_r && req |-> if (req_we) ##7 done_r else ##5 done_r)
        else $error("done pulse late or early");
    a_we_leads_cs: assert property (
        $fell(mem_cs_n_r) && !mem_we_n_r |-> $past(!mem_we_n_r))
        else $error("select fell before strobe");
    a_cs_pulse: assert property (
        $fell(mem_cs_n_r) && !mem_we_n_r |=> $rose(mem_cs_n_r) && !mem_we_n_r)
        else $error("select pulse wrong");
    a_we_trails_cs: assert property (
        $rose(mem_cs_n_r) && !mem_we_n_r |=>
            $rose(mem_we_n_r) && dq_oe_r ##1 !dq_oe_r)
        else $error("strobe did not trail select");
    a_data_driven: assert property (
        $rose(mem_cs_n_r) && !mem_we_n_r |-> dq_oe_r && $past(dq_oe_r, 2))
        else $error("data not driven before select rose");
    a_addr_held: assert property (
        $rose(mem_cs_n_r) |-> $past(mem_addr_r, 2) == mem_addr_r)
        else $error("address moved during select");
    a_write_gap: assert property (
        $rose(mem_we_n_r) |=> (mem_cs_n_r && $stable(mem_addr_r)) [*2])
        else $error("cycle gap too short");
    a_oe_in_write: assert property (!mem_we_n_r |-> mem_oe_n_r)
        else $error("output enable low in write");
    a_we_in_read: assert property (
        !mem_oe_n_r |-> mem_we_n_r && !dq_oe_r)
        else $error("strobe or data active in read");
endmodule // asw_ctrl_monitor
bind asw_ctrl asw_ctrl_monitor asw_ctrl_monitor_inst (.*);
`default_nettype wire

// file: verif/asw_mem_model.sv
// Behavioural asynchronous static memory facing the controller.
`timescale 1ns/1ps
`default_nettype none
`include "asw_ctrl_regs.vh"
module asw_mem_model (
    input wire logic [`ASW_ADDR_W-1:0] addr,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [`ASW_DATA_W-1:0] dq_ctrl,
    input wire logic dq_ctrl_oe,
    output wire logic [`ASW_DATA_W-1:0] dq
);
    logic [`ASW_DATA_W-1:0] arr [0:(1<<`ASW_ADDR_W)-1];
    logic [`ASW_DATA_W-1:0] last = 8'h00;
    wire logic drive = !cs_n && !oe_n && we_n;
    wire logic slow;
    // Data shows only after a slow-grade access delay.
    assign #(`ASW_T_ACC_NS) slow = drive;
    always @* if (!cs_n && !we_n) arr[addr] = dq;
    always @* if (dq_ctrl_oe) last = dq_ctrl; else if (drive && slow) last = arr[addr];
    // No pull on the lines, so an idle bus shows the inverse of its last value.
    assign dq = dq_ctrl_oe ? dq_ctrl : (drive && slow) ? arr[addr] : ~last;
endmodule // asw_mem_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
`default_nettype none
`include "asw_ctrl_regs.vh"
module tb;
    logic clk = 0, srst = 1, req = 0, req_we = 0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    wire ready_r, done_r, mem_cs_n_r, mem_we_n_r, mem_oe_n_r, dq_oe_r;
    wire [7:0] rdata_r, dq_out_r, dq_in;
    wire [14:0] mem_addr_r;
    int err_total = 0, check_count = 0;
    asw_ctrl asw_ctrl_inst (.*);
    asw_mem_model asw_mem_model_inst (.addr(mem_addr_r), .cs_n(mem_cs_n_r),
        .we_n(mem_we_n_r), .oe_n(mem_oe_n_r), .dq_ctrl(dq_out_r),
        .dq_ctrl_oe(dq_oe_r), .dq(dq_in));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // A stray request in the first busy cycle must be ignored.
    task automatic op(input logic we, input logic [14:0] a,
            input logic [7:0] d, input logic stray);
        int n;
        n = 0;
        while (ready_r !== 1'b1) begin
            @(posedge clk); #1;
            n++;
            if (n > 20) begin
                err_total++;
                give_verdict;
            end
        end
        req = 1; req_we = we; req_addr = a; req_wdata = d;
        @(posedge clk); #1;
        req = stray; req_wdata = ~d;
        @(posedge clk); #1;
        req = 0;
        n = 2;
        while (done_r !== 1'b1) begin
            @(posedge clk); #1;
            n++;
            if (n > 20) begin
                err_total++;
                give_verdict;
            end
        end
        check(n, we ? 15'd7 : 15'd5);
        if (!we) check({7'h00, rdata_r}, {7'h00, d});
    endtask
    task automatic s_idle;
        check({mem_cs_n_r, mem_we_n_r, mem_oe_n_r, dq_oe_r}, 15'h000e);
    endtask
    task automatic s_edges;
        op(1, 15'h0000, 8'h5a, 0);
        op(1, 15'h7fff, 8'ha5, 0);
        op(0, 15'h0000, 8'h5a, 0);
        op(0, 15'h7fff, 8'ha5, 0);
    endtask
    task automatic s_refuse;
        op(1, 15'h1234, 8'h3c, 1);
        op(0, 15'h1234, 8'h3c, 1);
        op(0, 15'h1234, 8'h3c, 0);
    endtask
    // Reset in mid-write must drop every strobe and leave the block idle.
    task automatic s_reset;
        req = 1; req_we = 1; req_addr = 15'h0042; req_wdata = 8'h99;
        @(posedge clk); #1;
        req = 0;
        @(posedge clk); #1;
        check({14'h0000, mem_cs_n_r}, 15'h0000);
        srst = 1;
        @(posedge clk); #1;
        check({mem_cs_n_r, mem_we_n_r, mem_oe_n_r, dq_oe_r}, 15'h000e);
        check({ready_r, done_r}, 15'h0000);
        check(mem_addr_r, 15'h0000);
        @(posedge clk); #1;
        srst = 0;
        @(posedge clk); #1;
        check({ready_r, done_r}, 15'h0002);
        op(0, 15'h0000, 8'h5a, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 srst = 0;
        @(posedge clk); #1;
        s_idle;
        s_edges;
        s_refuse;
        s_reset;
        give_verdict;
    end
endmodule // tb
`default_nettype wire
